/* verilog/boot_seq_pkg.sv */
// Package of constants and types for the power-on reset and boot sequencer
package boot_seq_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned BOOT_FIXED_US    = 2000;
   localparam int unsigned BOOT_PER_KB_US   = 3600;
   localparam int unsigned DEV_BOOT_US      = 1900;
   localparam int unsigned STABLE_US        = 100;
   localparam int unsigned BOOT_FIXED_CYC   = BOOT_FIXED_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BOOT_PER_KB_CYC  = BOOT_PER_KB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DEV_BOOT_CYC     = DEV_BOOT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned STABLE_CYC       = STABLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BYTES_PER_KB     = 1024;
   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W           = 13;
   localparam int unsigned PORT_W           = 10;
   localparam int unsigned CNT_W            = 32;
   localparam logic [ADDR_W-1:0] PC_RESET   = 13'h0000;
   localparam logic [PORT_W-1:0] LATCH_RESET = 10'h3ff;
   localparam logic              OD_RESET   = 1'b0;
   localparam logic [1:0]        CLK_SEL_INT = 2'h0;

   typedef enum logic [2:0] {
      ST_OFF, ST_HOLD, ST_COPY, ST_TAIL, ST_RUN
   } seq_state_t;
endpackage : boot_seq_pkg

/* verilog/power_on_reset_boot_sequencer.sv */
// Power-on reset, wake and boot copy sequencer
//
// What this block does
// - Power arrival is one reset cause and always asserts the single core reset.
// - Leaving shutdown asserts the same core reset although supply stayed up.
// - Shutdown ends on any low wake input or on expiry of an armed sleep timer.
// - In reset the core halts, registers take reset values, pins go known, interrupts and timers off.
// - Reset sets every port latch to all ones with open-drain drivers.
// - On release the program counter is zero and the internal oscillator is the clock source.
// - User code is copied from one_time_program_memory into code_data_ram before run starts at zero.
// - Boot lasts a fixed 2 ms plus 3.6 ms for each kilobyte copied, also after wake.
// - With no programmed user code a short startup under 2 ms is run instead.
// - No reset pin exists; power, wake and a debug reset on a blank part reset the device.
// - A debug reset on an unprogrammed part leaves code_data_ram untouched.
// - Internal data memory is declared lost after every reset.
// - A sleep timer wake after firmware shutdown runs the same boot as a power-on reset but sets wake_by_timer.
`timescale 1ns/1ps
module power_on_reset_boot_sequencer
   import boot_seq_pkg::*;
#(
   parameter int unsigned WAKE_W        = 10,
   parameter int unsigned STABLE_CYCLES = STABLE_CYC,
   parameter int unsigned FIXED_CYCLES  = BOOT_FIXED_CYC,
   parameter int unsigned KB_CYCLES     = BOOT_PER_KB_CYC,
   parameter int unsigned DEV_CYCLES    = DEV_BOOT_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          supply_good,
   input  wire logic                          osc_stable,
   input  wire logic                          shutdown_req,
   input  wire logic                          sleep_timer_armed,
   input  wire logic                          sleep_timer_expired,
   input  wire logic [WAKE_W-1:0]             wake_n,
   input  wire logic                          debug_reset_req,
   input  wire logic                          user_code_present,
   input  wire logic [boot_seq_pkg::ADDR_W-1:0] user_code_bytes,
   input  wire logic [7:0]                    otp_rdata,
   output logic                               core_rst_n,
   output logic                               core_run,
   output logic [boot_seq_pkg::ADDR_W-1:0]    pc_init,
   output logic [1:0]                         clk_sel,
   output logic [boot_seq_pkg::PORT_W-1:0]    port_latch,
   output logic [boot_seq_pkg::PORT_W-1:0]    port_push_pull,
   output logic                               irq_timers_en,
   output logic                               data_mem_lost,
   output logic                               internal_power_on,
   output logic                               otp_rd_en,
   output logic [boot_seq_pkg::ADDR_W-1:0]    otp_addr,
   output logic                               ram_wr_en,
   output logic [boot_seq_pkg::ADDR_W-1:0]    ram_addr,
   output logic [7:0]                         ram_wdata,
   output logic                               wake_by_timer
);
   import boot_seq_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [WAKE_W+4:0] sync1_q;
   logic [WAKE_W+4:0] sync2_q;
   wire  [WAKE_W+4:0] raw_in = {wake_n, supply_good, osc_stable, sleep_timer_armed,
                                sleep_timer_expired, debug_reset_req};

   // Two stages per input; logic reads only the second
   // No reset here: a held reset flushes both stages
   for (genvar i = 0; i < WAKE_W + 5; i++) begin : g_sync
      always_ff @(posedge clk) begin
         sync1_q[i] <= raw_in[i];
         sync2_q[i] <= sync1_q[i];
      end
   end

   wire [WAKE_W-1:0] wake_n_s  = sync2_q[WAKE_W+4:5];
   wire              supply_s  = sync2_q[4];
   wire              osc_s     = sync2_q[3];
   wire              armed_s   = sync2_q[2];
   wire              expired_s = sync2_q[1];
   wire              dbg_s     = sync2_q[0];

   // ------------------------------------------------------------
   // Wake decode
   // ------------------------------------------------------------
   // Pin wake: any input held low; timer wake only counts when armed
   wire pin_wake   = ~&wake_n_s;
   wire timer_wake = armed_s & expired_s;
   wire any_wake   = pin_wake | timer_wake;
   wire stable     = supply_s & osc_s;

   // ------------------------------------------------------------
   // State decode
   // ------------------------------------------------------------
   // Core is let go from the run state alone
   function automatic logic core_free(input seq_state_t s);
      return (s == ST_RUN);
   endfunction : core_free

   // Any state but off keeps internal power up
   function automatic logic powered(input seq_state_t s);
      return (s != ST_OFF);
   endfunction : powered

   // ------------------------------------------------------------
   // Boot length
   // ------------------------------------------------------------
   // Cycles for a boot; the product is kept in 64 bits to avoid overflow
   function automatic logic [CNT_W-1:0] boot_cycles(input logic [ADDR_W-1:0] bytes,
                                                    input logic              present);
      logic [63:0] prod;
      logic [63:0] total;
      prod  = 64'(bytes) * 64'(KB_CYCLES);
      total = 64'(FIXED_CYCLES) + prod / 64'(BYTES_PER_KB);
      return present ? total[CNT_W-1:0] : CNT_W'(DEV_CYCLES);
   endfunction : boot_cycles

   wire [CNT_W-1:0] boot_len = boot_cycles(user_code_bytes, user_code_present);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   seq_state_t       state_q, state_d;
   logic [CNT_W-1:0] cnt_q,   cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic             prog_q,  prog_d;
   logic             timer_q, timer_d;

   wire copy_done = (addr_q == user_code_bytes);
   wire time_done = (cnt_q >= boot_len);
   // Debug reset on a blank part reboots without a copy, so RAM survives;
   // only the rising edge counts, so a held request reboots once
   logic dbg_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dbg_q <= 1'b0;
      end else begin
         dbg_q <= dbg_s;
      end
   end

   wire dbg_reboot = dbg_s & ~dbg_q & ~user_code_present;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      addr_d  = addr_q;
      prog_d  = prog_q;
      timer_d = timer_q;
      case (state_q)
         ST_OFF: begin
            cnt_d  = '0;
            addr_d = '0;
            // Only power and wake leave here; no reset pin exists
            if (stable && (any_wake || !prog_q)) begin
               state_d = ST_HOLD;
               timer_d = timer_wake & prog_q;
            end
         end
         ST_HOLD: begin
            cnt_d = cnt_q + 1'b1;
            if (!stable) begin
               cnt_d = '0;
            end else if (cnt_q >= CNT_W'(STABLE_CYCLES - 1)) begin
               cnt_d   = '0;
               state_d = user_code_present ? ST_COPY : ST_TAIL;
            end
         end
         ST_COPY: begin
            cnt_d  = cnt_q + 1'b1;
            addr_d = addr_q + 1'b1;
            if (copy_done) begin
               addr_d  = addr_q;
               state_d = ST_TAIL;
            end
         end
         ST_TAIL: begin
            cnt_d = cnt_q + 1'b1;
            if (time_done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            prog_d = 1'b1;
            if (shutdown_req) begin
               state_d = ST_OFF;
            end else if (dbg_reboot) begin
               state_d = ST_HOLD;
               cnt_d   = '0;
            end
         end
         default: state_d = ST_OFF;
      endcase
      if (!stable) begin
         state_d = ST_OFF;
         prog_d  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_OFF;
         cnt_q   <= '0;
         addr_q  <= '0;
         prog_q  <= 1'b0;
         timer_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         prog_q  <= prog_d;
         timer_q <= timer_d;
      end
   end

   // ------------------------------------------------------------
   // Copy datapath
   // ------------------------------------------------------------
   // The array answers one cycle after the request, so the write trails the read by two
   logic              rd_q;
   logic [ADDR_W-1:0] ra_q;
   logic              wr_q;
   logic [ADDR_W-1:0] wa_q;
   logic [7:0]        wd_q;
   wire               rd = (state_q == ST_COPY) & ~copy_done;

   // Request stage: which address the array is answering
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         ra_q <= '0;
      end else begin
         rd_q <= rd;
         ra_q <= addr_q;
      end
   end

   // Write stage: data is taken while the array presents it; dropped if power fails
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         wa_q <= '0;
         wd_q <= 8'h00;
      end else begin
         wr_q <= rd_q & powered(state_q);
         wa_q <= ra_q;
         wd_q <= otp_rdata;
      end
   end

   assign otp_rd_en = rd;
   assign otp_addr  = addr_q;
   assign ram_wr_en = wr_q;
   assign ram_addr  = wa_q;
   assign ram_wdata = wd_q;

   // ------------------------------------------------------------
   // Core and port control
   // ------------------------------------------------------------
   logic run_q;
   logic rst_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         run_q <= core_free(state_d);
         rst_q <= core_free(state_d);
      end
   end

   // ------------------------------------------------------------
   // Port latches
   // ------------------------------------------------------------
   // Loaded whenever the core is held; firmware updates live outside this block
   // Per-pin flops so a later writer can own single pins
   logic [PORT_W-1:0] latch_q;
   logic [PORT_W-1:0] pp_q;

   for (genvar p = 0; p < PORT_W; p++) begin : g_port
      always_ff @(posedge clk) begin
         if (!rst_n || !rst_q) begin
            latch_q[p] <= LATCH_RESET[p];
            pp_q[p]    <= OD_RESET;
         end
      end
   end

   assign core_run          = run_q;
   assign core_rst_n        = rst_q;
   assign pc_init           = PC_RESET;
   assign clk_sel           = CLK_SEL_INT;
   assign port_latch        = latch_q;
   assign port_push_pull    = pp_q;
   assign irq_timers_en     = rst_q;
   assign data_mem_lost     = ~rst_q;
   assign internal_power_on = powered(state_q);
   assign wake_by_timer     = timer_q;
endmodule : power_on_reset_boot_sequencer

/* tb/power_on_reset_boot_sequencer_assertions.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module boot_seq_checker
   import boot_seq_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     shutdown_req,
   input wire logic                     core_rst_n,
   input wire logic                     core_run,
   input wire logic                     irq_timers_en,
   input wire logic                     data_mem_lost,
   input wire logic                     internal_power_on,
   input wire logic                     otp_rd_en,
   input wire logic                     ram_wr_en,
   input wire logic [1:0]               clk_sel,
   input wire logic [boot_seq_pkg::PORT_W-1:0] port_latch,
   input wire logic [boot_seq_pkg::PORT_W-1:0] port_push_pull,
   input wire logic [boot_seq_pkg::ADDR_W-1:0] pc_init,
   input wire logic [boot_seq_pkg::ADDR_W-1:0] otp_addr,
   input wire logic [boot_seq_pkg::ADDR_W-1:0] ram_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_latch_ones: assert property (!core_rst_n |-> port_latch == LATCH_RESET)
      else $error("port latch not all ones in reset");
   chk_open_drain: assert property (!core_rst_n |-> port_push_pull == '0)
      else $error("port driver not open drain in reset");
   chk_core_quiet: assert property (!core_rst_n |-> !core_run && !irq_timers_en && data_mem_lost)
      else $error("core not quiet in reset");
   chk_off_holds: assert property (!internal_power_on |-> !core_rst_n)
      else $error("core released while unpowered");
   chk_copy_first: assert property (ram_wr_en |-> !core_rst_n && !core_run)
      else $error("ram written while core runs");
   chk_write_pairs: assert property (ram_wr_en |-> $past(otp_rd_en, 2) && ram_addr == $past(otp_addr, 2))
      else $error("ram write without matching read");
   chk_start_zero: assert property ($rose(core_rst_n) |-> pc_init == PC_RESET && clk_sel == CLK_SEL_INT)
      else $error("start address or clock wrong");
   chk_shutdown_drop: assert property (core_run && shutdown_req |-> ##[1:6] !core_rst_n)
      else $error("shutdown did not reset core");
   cover property ($rose(core_rst_n));
   cover property (ram_wr_en);
   cover property (core_run && shutdown_req);
endmodule : boot_seq_checker

bind power_on_reset_boot_sequencer boot_seq_checker u_chk (.clk, .rst_n, .shutdown_req, .core_rst_n, .core_run,
   .irq_timers_en, .data_mem_lost, .internal_power_on, .otp_rd_en, .ram_wr_en, .clk_sel, .port_latch,
   .port_push_pull, .pc_init, .otp_addr, .ram_addr);

/* tb/boot_env_model.sv */
// Supply, oscillator, wake buttons, sleep timer and code memory
`timescale 1ns/1ps
module boot_env_model (
   input  wire logic        clk,
   input  wire logic        pwr,
   input  wire logic        press,
   input  wire logic        arm,
   input  wire logic        fire,
   input  wire logic        otp_rd_en,
   input  wire logic [boot_seq_pkg::ADDR_W-1:0] otp_addr,
   output logic             supply_good,
   output logic             osc_stable,
   output logic [9:0]       wake_n,
   output logic             sleep_timer_armed,
   output logic             sleep_timer_expired,
   output logic [7:0]       otp_rdata
);
   logic [1:0] osc_q;
   assign supply_good = pwr;
   assign osc_stable = osc_q[1];
   // Pull-ups keep idle buttons high
   assign wake_n = press ? 10'h3f7 : 10'h3ff;
   assign sleep_timer_armed = arm;
   assign sleep_timer_expired = fire;
   // Oscillator lags supply; idle read data is inverted so stale bytes never match
   always @(posedge clk) begin
      osc_q <= pwr ? {osc_q[0], 1'b1} : 2'h0;
      otp_rdata <= otp_rd_en ? (otp_addr[7:0] ^ 8'h5a) : ~(otp_addr[7:0] ^ 8'h5a);
   end
endmodule : boot_env_model

/* tb/power_on_reset_boot_sequencer_tb.sv */
// Self-checking testbench for the sequencer
`timescale 1ns/1ps
module power_on_reset_boot_sequencer_tb;
   import boot_seq_pkg::*;
   localparam int STB = 4, FIX = 20, KBC = 2048, DEV = 15, NB = 16;
   localparam int LO = STB + FIX + NB * KBC / 1024;
   logic clk = 1'b0, rst_n = 1'b0, shutdown_req = 1'b0, debug_reset_req = 1'b0, user_code_present = 1'b1;
   logic pwr = 1'b0, press = 1'b0, arm = 1'b0, fire = 1'b0;
   logic [ADDR_W-1:0] user_code_bytes = 13'h0010;
   logic supply_good, osc_stable, sleep_timer_armed, sleep_timer_expired, core_rst_n, core_run;
   logic irq_timers_en, data_mem_lost, internal_power_on, otp_rd_en, ram_wr_en, wake_by_timer;
   logic [9:0] wake_n;
   logic [7:0] otp_rdata, ram_wdata;
   logic [1:0] clk_sel;
   logic [PORT_W-1:0] port_latch, port_push_pull;
   logic [ADDR_W-1:0] pc_init, otp_addr, ram_addr;
   int mismatches = 0, compares = 0, wr_cnt = 0;
   always #20 clk = ~clk;
   boot_env_model env (.clk, .pwr, .press, .arm, .fire, .otp_rd_en, .otp_addr, .supply_good, .osc_stable,
      .wake_n, .sleep_timer_armed, .sleep_timer_expired, .otp_rdata);
   power_on_reset_boot_sequencer #(.STABLE_CYCLES(STB), .FIXED_CYCLES(FIX), .KB_CYCLES(KBC),
      .DEV_CYCLES(DEV)) dut (.clk, .rst_n, .supply_good, .osc_stable, .shutdown_req, .sleep_timer_armed,
      .sleep_timer_expired, .wake_n, .debug_reset_req, .user_code_present, .user_code_bytes, .otp_rdata,
      .core_rst_n, .core_run, .pc_init, .clk_sel, .port_latch, .port_push_pull, .irq_timers_en, .data_mem_lost,
      .internal_power_on, .otp_rd_en, .otp_addr, .ram_wr_en, .ram_addr, .ram_wdata, .wake_by_timer);
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic chk_val(input string nm, input logic [12:0] e, input logic [12:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val
   task automatic chk_time(input int n, input int lo, input int hi);
      compares++;
      if (n < lo || n > hi) begin
         mismatches++;
         $display("MISMATCH boot_cycles expected %0d..%0d seen %0d", lo, hi, n);
      end
   endtask : chk_time
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   // Negedge sampling keeps clear of the launching edge
   always @(negedge clk) begin
      if (ram_wr_en === 1'b1) begin
         chk_val("ram_addr", 13'(wr_cnt), ram_addr);
         chk_val("ram_wdata", {5'h0, wr_cnt[7:0] ^ 8'h5a}, {5'h0, ram_wdata});
         wr_cnt++;
      end
   end
   task automatic wait_boot(input int lo, input int hi);
      int n;
      n = 0;
      while (internal_power_on !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk_val("power_on", 13'h1, {12'h0, internal_power_on});
      if (n >= 200) stop_test();
      chk_val("latch", {3'h0, LATCH_RESET}, {3'h0, port_latch});
      chk_val("push_pull", 13'h0, {3'h0, port_push_pull});
      chk_val("quiet", 13'h1, {10'h0, core_run, irq_timers_en, data_mem_lost});
      n = 0;
      while (core_rst_n !== 1'b1 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk_time(n, lo, hi);
      chk_val("start", PC_RESET, pc_init);
      chk_val("clk_sel", {11'h0, CLK_SEL_INT}, {11'h0, clk_sel});
      if (n >= 2000) stop_test();
   endtask : wait_boot
   task automatic t_wake(input logic by_timer);
      wr_cnt = 0;
      arm = by_timer;
      cyc(4);
      shutdown_req = 1'b1;
      cyc(1);
      shutdown_req = 1'b0;
      fire = !by_timer;
      cyc(10);
      chk_val("asleep", 13'h0, {11'h0, core_rst_n, internal_power_on});
      press = !by_timer;
      fire = by_timer;
      wait_boot(LO, LO + 6);
      chk_val("copied", 13'(NB), 13'(wr_cnt));
      chk_val("by_timer", {12'h0, by_timer}, {12'h0, wake_by_timer});
      press = 1'b0;
      fire = 1'b0;
   endtask : t_wake
   task automatic t_blank();
      wr_cnt = 0;
      pwr = 1'b0;
      user_code_present = 1'b0;
      cyc(8);
      chk_val("off", 13'h0, {11'h0, core_rst_n, internal_power_on});
      pwr = 1'b1;
      wait_boot(1, STB + FIX - 1);
      debug_reset_req = 1'b1;
      cyc(6);
      debug_reset_req = 1'b0;
      chk_val("dbg_rst", 13'h0, {12'h0, core_rst_n});
      wait_boot(1, STB + FIX - 1);
      chk_val("copied", 13'h0, 13'(wr_cnt));
   endtask : t_blank
   initial begin
      repeat (4) @(posedge clk);
      #2;
      rst_n = 1'b1;
      pwr = 1'b1;
      wait_boot(LO, LO + 6);
      chk_val("copied", 13'(NB), 13'(wr_cnt));
      debug_reset_req = 1'b1;
      cyc(8);
      debug_reset_req = 1'b0;
      chk_val("dbg_ignored", 13'h1, {12'h0, core_rst_n});
      t_wake(1'b0);
      t_wake(1'b1);
      t_blank();
      stop_test();
   end
endmodule : power_on_reset_boot_sequencer_tb
